// ### core/bpx_if.sv
// Interface between the port top and each interrupt line block.
// Assumes both sides run on core_clk.
`timescale 1ns/10ps
`default_nettype none
interface bpx_irq_if;
  logic       src;        // Combined source level after forcing
  logic [1:0] sense;      // Selected sensitivity
  logic       sense_wr;   // Write that changes the sensitivity
  logic       vec_fetch;  // CPU fetched this vector
  logic       pending;    // Pending request latch

  modport top  (output src, output sense, output sense_wr, output vec_fetch, input pending);
  modport line (input src, input sense, input sense_wr, input vec_fetch, output pending);
endinterface : bpx_irq_if
`default_nettype wire

// ### core/bpx_irq_line.sv
// One external interrupt line: edge detector and pending latch.
// Assumes its source level is already synchronised to core_clk.
`timescale 1ns/10ps
`default_nettype none
module bpx_irq_line
  import bpx_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  bpx_irq_if.line   irq
);
  logic src_d_r;
  logic pend_r;
  logic rise;
  logic fall;
  logic hit;

  // Edge and level decode for the chosen sensitivity
  assign rise = irq.src & ~src_d_r;
  assign fall = ~irq.src & src_d_r;
  assign hit  = (irq.sense == BPX_SENS_FALL_LOW) ? (fall | ~irq.src) :
                (irq.sense == BPX_SENS_RISE)     ? rise :
                (irq.sense == BPX_SENS_FALL)     ? fall : (rise | fall); // RULE5

  // Previous level resets to 1, matching the forced idle level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      src_d_r <= 1'b1;
    end else begin
      src_d_r <= irq.src;
    end
  end

  // New event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (hit) begin
      pend_r <= 1'b1;
    end else if (irq.vec_fetch || irq.sense_wr) begin
      pend_r <= 1'b0; // RULE7 RULE8
    end
  end

  assign irq.pending = pend_r;
endmodule : bpx_irq_line
`default_nettype wire

// ### core/bpx_pkg.sv
// Package for the bidirectional port with external interrupt lines.
// Assumes a single core clock domain and a plain strobe register port.
package bpx_pkg;

  localparam int unsigned BPX_PINS     = 6;
  localparam int unsigned BPX_ADDR_W   = 2;
  localparam int unsigned BPX_DATA_W   = 8;
  // Register offsets
  localparam logic [1:0]  BPX_OFF_VALUE = 2'h0;
  localparam logic [1:0]  BPX_OFF_DIR   = 2'h1;
  localparam logic [1:0]  BPX_OFF_OPT   = 2'h2;
  localparam logic [1:0]  BPX_OFF_SENSE = 2'h3;
  // Reset values
  localparam logic [7:0]  BPX_RST_VALUE = 8'h00;
  localparam logic [7:0]  BPX_RST_DIR   = 8'h08;
  localparam logic [7:0]  BPX_RST_OPT   = 8'h02;
  localparam logic [7:0]  BPX_RST_SENSE = 8'h00;
  // Index of the output-only pin
  localparam int unsigned BPX_OUT_ONLY  = 3;
  // Sensitivity codes, two bits per pin group
  localparam logic [1:0]  BPX_SENS_FALL_LOW = 2'h0;
  localparam logic [1:0]  BPX_SENS_RISE     = 2'h1;
  localparam logic [1:0]  BPX_SENS_FALL     = 2'h2;
  localparam logic [1:0]  BPX_SENS_BOTH     = 2'h3;
  // Number of interrupt vectors, pins per vector fixed by a map
  localparam int unsigned BPX_VECS      = 4;
  // Pin group of each vector: bit n set means pin n feeds the vector
  localparam logic [5:0]  BPX_VEC_MAP0  = 6'h01;
  localparam logic [5:0]  BPX_VEC_MAP1  = 6'h02;
  localparam logic [5:0]  BPX_VEC_MAP2  = 6'h04;
  localparam logic [5:0]  BPX_VEC_MAP3  = 6'h30;

endpackage : bpx_pkg

// ### core/bpx_port.sv
// Bidirectional six-pin port with direction, option and value registers,
// alternate function override and edge- or low-level-triggered external interrupts.
// Assumes pins arrive asynchronously and the CPU gives vector fetch pulses.
//
// Contract
// RULE1 - Bit n of each register controls pin n
// RULE2 - Input mode: value reads return pin level
// RULE3 - Input mode: writes update latch only
// RULE4 - Output-only pin never acts as input
// RULE5 - Per-pin interrupt on its programmed sensitivity
// RULE6 - Shared-vector pins combined, low pin masks
// RULE7 - Vector fetch clears pending request
// RULE8 - Sensitivity change clears pending request
// RULE9 - Disabled interrupt forces detector input high
// RULE10 - Software enable sequence avoids spurious edge
// RULE11 - Software disable sequence avoids spurious edge
// RULE12 - Output mode drives latch, reads latch
// RULE13 - Option selects push-pull or open-drain
// RULE14 - Software writes value before selecting output
// RULE15 - Peripheral output overrides standard pin settings
// RULE16 - Peripheral inputs use floating input, readable
// RULE17 - Input with alternate output reads alternate
// RULE18 - Output with alternate input sees latch
// RULE19 - No alternate function on interrupt inputs
// RULE20 - Analog inputs configured as floating input
// RULE21 - Low power keeps state, interrupt wakes
// RULE22 - Interrupt needs input-interrupt mode, mask clear
// RULE23 - Option bit meaning per direction
// RULE24 - Pin inputs synchronised before use
`timescale 1ns/10ps
`default_nettype none
module bpx_port
  import bpx_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [BPX_ADDR_W-1:0] reg_addr,
  input  wire logic [BPX_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [BPX_DATA_W-1:0] reg_rdata,
  // Pads
  input  wire logic [BPX_PINS-1:0]   pin_in,
  output logic      [BPX_PINS-1:0]   pin_out,
  output logic      [BPX_PINS-1:0]   pin_oe_n,
  output logic      [BPX_PINS-1:0]   pin_pullup,
  // Alternate functions
  input  wire logic [BPX_PINS-1:0]   alt_out_en,
  input  wire logic [BPX_PINS-1:0]   alt_out_val,
  input  wire logic [BPX_PINS-1:0]   alt_out_od,
  input  wire logic [BPX_PINS-1:0]   alt_in_en,
  output logic      [BPX_PINS-1:0]   alt_in_val,
  // CPU side
  input  wire logic                  cpu_irq_mask,
  input  wire logic [BPX_VECS-1:0]   vec_fetch,
  input  wire logic                  low_power,
  output logic      [BPX_VECS-1:0]   irq_req,
  output logic                       wake_req
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and synchroniser
  logic [BPX_PINS-1:0] value_r;
  logic [BPX_PINS-1:0] dir_r;
  logic [BPX_PINS-1:0] opt_r;
  logic [7:0]          sense_r;
  logic [BPX_PINS-1:0] sync1_r;
  logic [BPX_PINS-1:0] sync2_r;
  logic [BPX_DATA_W-1:0] rdata_r;
  logic [BPX_PINS-1:0] pout_r;
  logic [BPX_PINS-1:0] poe_n_r;
  logic [BPX_PINS-1:0] pup_r;
  logic [BPX_PINS-1:0] alt_in_r;
  logic [BPX_VECS-1:0] irq_r;
  logic                wake_r;

  // Two-stage pin synchroniser; only stage two is read by logic.
  // Resets high to match the detectors' idle level, so no false edge follows reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r; // RULE24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin mode decode
  logic [BPX_PINS-1:0] eff_dir;
  logic [BPX_PINS-1:0] in_irq;
  logic [BPX_PINS-1:0] drive_lvl;
  logic [BPX_PINS-1:0] drive_od;
  logic [BPX_PINS-1:0] oe_n_nxt;
  logic [BPX_PINS-1:0] pup_nxt;
  logic [BPX_PINS-1:0] pin_val;
  logic [BPX_PINS-1:0] rd_value;
  logic [BPX_PINS-1:0] out_only;
  logic [BPX_PINS-1:0] src_lvl;

  assign out_only  = BPX_PINS'(1) << BPX_OUT_ONLY;
  // Output-only pin is always an output; peripheral output forces output
  assign eff_dir   = dir_r | out_only | alt_out_en; // RULE4 RULE15
  assign in_irq    = ~eff_dir & opt_r; // RULE23
  // Alternate output level and drive kind take priority
  assign drive_lvl = alt_out_en & alt_out_val | ~alt_out_en & value_r; // RULE15 RULE12
  assign drive_od  = alt_out_en & alt_out_od | ~alt_out_en & ~opt_r; // RULE13 RULE23
  // Low drives in both kinds, high drives only when push-pull
  assign oe_n_nxt  = ~(eff_dir & (~drive_lvl | ~drive_od)); // RULE13
  assign pup_nxt   = ~eff_dir & opt_r; // RULE23
  assign pin_val   = sync2_r;
  // Reads: pin level in input, latch in output, alternate output if enabled on an input
  assign rd_value  = (dir_r | out_only) & value_r |
                     ~(dir_r | out_only) & alt_out_en & alt_out_val |
                     ~(dir_r | out_only) & ~alt_out_en & pin_val; // RULE2 RULE12 RULE17 RULE16
  // Interrupt source forced to 1 while interrupt is disabled
  assign src_lvl   = in_irq & pin_val | ~in_irq; // RULE9

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  logic wr_value;
  logic wr_dir;
  logic wr_opt;
  logic wr_sense;
  logic [7:0] sense_chg;

  assign wr_value  = reg_wr && (reg_addr == BPX_OFF_VALUE);
  assign wr_dir    = reg_wr && (reg_addr == BPX_OFF_DIR);
  assign wr_opt    = reg_wr && (reg_addr == BPX_OFF_OPT);
  assign wr_sense  = reg_wr && (reg_addr == BPX_OFF_SENSE);
  assign sense_chg = wr_sense ? (reg_wdata ^ sense_r) : 8'h00;

  // Value write only touches the latch; pins follow only in output mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      value_r <= BPX_RST_VALUE[BPX_PINS-1:0];
      dir_r   <= BPX_RST_DIR[BPX_PINS-1:0];
      opt_r   <= BPX_RST_OPT[BPX_PINS-1:0];
      sense_r <= BPX_RST_SENSE;
    end else begin
      if (wr_value) value_r <= reg_wdata[BPX_PINS-1:0]; // RULE3 RULE1
      if (wr_dir)   dir_r   <= reg_wdata[BPX_PINS-1:0]; // RULE1
      if (wr_opt)   opt_r   <= reg_wdata[BPX_PINS-1:0]; // RULE1
      if (wr_sense) sense_r <= reg_wdata;
    end
  end

  // Read mux; upper bits read as zero except on the sense register, which reads all 8 bits
  logic [BPX_DATA_W-1:0] rd_mux;
  assign rd_mux = (reg_addr == BPX_OFF_VALUE) ? {2'b00, rd_value} :
                  (reg_addr == BPX_OFF_DIR)   ? {2'b00, dir_r} :
                  (reg_addr == BPX_OFF_OPT)   ? {2'b00, opt_r} : sense_r;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt lines, one per vector
  logic [BPX_PINS-1:0] vec_map [BPX_VECS];
  logic [BPX_VECS-1:0] pend;
  assign vec_map[0] = BPX_VEC_MAP0;
  assign vec_map[1] = BPX_VEC_MAP1;
  assign vec_map[2] = BPX_VEC_MAP2;
  assign vec_map[3] = BPX_VEC_MAP3;

  genvar v;
  generate
    for (v = 0; v < BPX_VECS; v++) begin : g_vec
      bpx_irq_if lnk ();
      // Pins of a group are ANDed, so one low pin masks the rest
      assign lnk.src       = &(src_lvl | ~vec_map[v]); // RULE6
      assign lnk.sense     = sense_r[2*v +: 2]; // RULE5
      assign lnk.sense_wr  = |sense_chg[2*v +: 2]; // RULE8
      assign lnk.vec_fetch = vec_fetch[v]; // RULE7
      assign pend[v]       = lnk.pending;
      bpx_irq_line u_line (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .irq      (lnk.line)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output registers
  // Pin and alternate input state is untouched by low power; only the
  // wake output depends on it, since the port itself keeps running.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pout_r   <= '0;
      poe_n_r  <= '1;
      pup_r    <= '0;
      alt_in_r <= '0;
      irq_r    <= '0;
      wake_r   <= 1'b0;
    end else begin
      pout_r   <= drive_lvl; // RULE12
      poe_n_r  <= oe_n_nxt; // RULE13 RULE21
      pup_r    <= pup_nxt; // RULE23
      // Peripheral input sees latch when pin is an output
      alt_in_r <= alt_in_en & (eff_dir & value_r | ~eff_dir & pin_val); // RULE18 RULE16
      irq_r    <= pend & {BPX_VECS{~cpu_irq_mask}}; // RULE22
      wake_r   <= low_power & (|pend); // RULE21
    end
  end

  assign reg_rdata  = rdata_r;
  assign pin_out    = pout_r;
  assign pin_oe_n   = poe_n_r;
  assign pin_pullup = pup_r;
  assign alt_in_val = alt_in_r;
  assign irq_req    = irq_r;
  assign wake_req   = wake_r;

endmodule : bpx_port
`default_nettype wire

// ### tb/bpx_pads.sv
// Pad model: board drivers, pull-ups and floating pins.
// Assumes the port's enables are low while it drives.
`timescale 1ns/10ps
`default_nettype none
module bpx_pads
(
  input  wire logic       core_clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [5:0] pin_pullup,
  input  wire logic [5:0] ext_drv,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pin_lvl
);
  logic [5:0] flt_r = 6'h00;
  // A floating pad wanders, so a stale level never passes for a read
  always_ff @(posedge core_clk) begin
    flt_r <= ~flt_r;
  end
  // Port drive wins, then board drive, then pull-up or float
  assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drv & ext_val)
                 | (pin_oe_n & ~ext_drv & (pin_pullup | flt_r));
endmodule : bpx_pads
`default_nettype wire

// ### tb/bpx_port_assertions.sv
// Port checker: read answer, pad enables, interrupt requests, wake.
// Assumes binding onto bpx_port; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module bpx_port_assertions
  import bpx_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [1:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic [5:0]        pin_in,
  input wire logic [5:0]        pin_oe_n,
  input wire logic [5:0]        pin_pullup,
  input wire logic [5:0]        alt_out_en,
  input wire logic              cpu_irq_mask,
  input wire logic [3:0]        vec_fetch,
  input wire logic              low_power,
  input wire logic [3:0]        irq_req,
  input wire logic              wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Shadow of vector 0 sensitivity, so a rewrite of the same code is not a change
  logic [1:0] sns0_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) sns0_r <= BPX_RST_SENSE[1:0];
    else if (reg_wr && reg_addr == BPX_OFF_SENSE) sns0_r <= reg_wdata[1:0];
  end
  // Pin 0 held high and unrouted: no event can be in flight
  sequence s_quiet0;
    ($stable(pin_in[0]) && pin_in[0] && !alt_out_en[0]) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_pin3_nopull: assert property (pin_pullup[BPX_OUT_ONLY] == 1'b0)
    else $error("output-only pin pulled up");
  a_pull_drive_excl: assert property ((pin_pullup & ~pin_oe_n) == 6'h00)
    else $error("pull-up on a driven pin");
  a_mask_blocks: assert property ($past(cpu_irq_mask) |-> irq_req == 4'h0)
    else $error("request while masked");
  a_fetch_clears: assert property (s_quiet0 ##0 vec_fetch[0] |-> ##3 !irq_req[0])
    else $error("fetch did not clear request");
  a_sense_clears: assert property (s_quiet0 ##0 (reg_wr && reg_addr == BPX_OFF_SENSE
    && reg_wdata[1:0] != sns0_r) |-> ##3 !irq_req[0]) else $error("sense change kept request");
  a_wake_on_irq: assert property ((|irq_req) && $past(low_power) |-> wake_req)
    else $error("no wake on pending request");
  a_wake_idle: assert property (!$past(low_power) |-> !wake_req)
    else $error("wake outside low power");
endmodule : bpx_port_assertions
bind bpx_port bpx_port_assertions u_bpx_port_assertions (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_oe_n, .pin_pullup, .alt_out_en,
  .cpu_irq_mask, .vec_fetch, .low_power, .irq_req, .wake_req);
`default_nettype wire

// ### tb/bpx_port_tb.sv
// Testbench for the port: registers, pad modes, alternates, interrupts.
// Assumes the pad model and checker from tb/.
`timescale 1ns/10ps
`default_nettype none
module bpx_port_tb
  import bpx_pkg::*;
;
  `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  logic       core_clk, rst_n, reg_wr, reg_rd, cpu_irq_mask, low_power, wake_req;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [5:0] pin_lvl, pin_out, pin_oe_n, pin_pullup, alt_out_en, alt_out_val;
  logic [5:0] alt_in_en, alt_in_val, alt_out_od, ext_drv, ext_val, v, o, e, w;
  logic [3:0] vec_fetch, irq_req;
  logic [7:0] rst_exp [4] = '{BPX_RST_VALUE, BPX_RST_DIR, BPX_RST_OPT, BPX_RST_SENSE};
  int         error_cnt, n_checks;
  bpx_port u_bpx_port (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_in(pin_lvl), .pin_out, .pin_oe_n, .pin_pullup, .alt_out_en,
    .alt_out_val, .alt_out_od, .alt_in_en, .alt_in_val, .cpu_irq_mask, .vec_fetch,
    .low_power, .irq_req, .wake_req);
  bpx_pads u_bpx_pads (.core_clk, .pin_out, .pin_oe_n, .pin_pullup, .ext_drv, .ext_val,
    .pin_lvl);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Tasks return just past an edge so later drives never race it
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [1:0] a, input logic [7:0] x);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= x;
    tick(1);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd   <= 1'b0;
    q = reg_rdata;
  endtask : rd
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, cpu_irq_mask, low_power, reg_addr, reg_wdata} = '0;
    {alt_out_en, alt_out_val, alt_out_od, alt_in_en, vec_fetch} = '0;
    // Board holds the input pins, pin 1 at its pulled-up idle level
    ext_drv = 6'h37;
    ext_val = 6'h02;
    void'($urandom(68745));
    tick(8);
    rst_n <= 1'b1;
    // Pin reads trail the pads by the two synchroniser stages
    tick(2);
    // Value reads show the input pins, and the latch only on pin 3
    rst_exp[0] = {2'h0, 6'h02 | (BPX_RST_VALUE[5:0] & 6'h08)};
    foreach (rst_exp[i]) begin
      rd(2'(i), d);
      `CHK("reset value", rst_exp[i], d)
    end
    `CHK("pin3 drive", 2'b00, {pin_oe_n[3], pin_out[3]})
    // Inputs read the pads; value writes only reach the latch
    wr(BPX_OFF_DIR, 8'h00);
    repeat (4) begin
      e = 6'($urandom);
      v = 6'($urandom);
      ext_val <= e;
      wr(BPX_OFF_VALUE, {2'h0, v});
      tick(3);
      rd(BPX_OFF_VALUE, d);
      `CHK("input read", {2'h0, (e & 6'h37) | (v & 6'h08)}, d)
      `CHK("input undriven", 6'h37, pin_oe_n & 6'h37)
    end
    // Outputs: value first, then direction; option picks the driver kind
    ext_drv <= 6'h00;
    repeat (4) begin
      v = 6'($urandom);
      o = 6'($urandom);
      wr(BPX_OFF_DIR, 8'h00);
      wr(BPX_OFF_VALUE, {2'h0, v});
      wr(BPX_OFF_OPT, {2'h0, o});
      wr(BPX_OFF_DIR, 8'h3F);
      rd(BPX_OFF_VALUE, d);
      `CHK("output read", {2'h0, v}, d)
      `CHK("output enable", ~(o | ~v), pin_oe_n)
      `CHK("output level", v | ~(o | ~v), pin_out | pin_oe_n)
    end
    wr(BPX_OFF_DIR, 8'h00);
    tick(2);
    `CHK("pull-up", o & 6'h37, pin_pullup)
    // Alternates on floating inputs, either driver kind, then peripheral inputs
    wr(BPX_OFF_OPT, 8'h00);
    w = 6'($urandom);
    o = 6'($urandom);
    alt_out_val <= w;
    alt_out_od  <= o;
    alt_out_en  <= 6'h37;
    tick(3);
    rd(BPX_OFF_VALUE, d);
    `CHK("alt read", w & 6'h37, d[5:0] & 6'h37)
    `CHK("alt drive", w & 6'h37, (pin_out | pin_oe_n) & 6'h37)
    `CHK("alt drive kind", w & o & 6'h37, pin_oe_n & 6'h37)
    alt_out_en <= 6'h00;
    alt_in_en  <= 6'h3F;
    wr(BPX_OFF_DIR, 8'h3F);
    tick(2);
    `CHK("alt input", v, alt_in_val)
    // Peripheral inputs on floating inputs follow the pads
    e = 6'($urandom);
    ext_drv <= 6'h3F;
    ext_val <= e;
    wr(BPX_OFF_DIR, 8'h00);
    tick(4);
    `CHK("alt pin input", (e & 6'h37) | (v & 6'h08), alt_in_val)
    // Safe enable of pin 0 interrupt, then every sensitivity code
    alt_in_en    <= 6'h00;
    ext_val      <= 6'h3F;
    cpu_irq_mask <= 1'b1;
    wr(BPX_OFF_SENSE, {6'h00, BPX_SENS_RISE});
    wr(BPX_OFF_OPT, 8'h01);
    cpu_irq_mask <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(BPX_OFF_SENSE, {6'h00, 2'(c)});
      tick(3);
      `CHK("sense change", 1'b0, irq_req[0])
      ext_val[0] <= 1'b0;
      tick(6);
      `CHK("fall event", c != 1, irq_req[0])
      ext_val[0] <= 1'b1;
      tick(6);
    end
    cpu_irq_mask <= 1'b1;
    low_power    <= 1'b1;
    tick(3);
    `CHK("masked", 4'h0, irq_req)
    `CHK("wake", 1'b1, wake_req)
    cpu_irq_mask <= 1'b0;
    low_power    <= 1'b0;
    tick(3);
    `CHK("unmasked", 1'b1, irq_req[0])
    vec_fetch <= 4'h1;
    tick(1);
    vec_fetch <= 4'h0;
    tick(3);
    `CHK("fetch clear", 1'b0, irq_req[0])
    // Disabling with the pin low makes the forced-high edge
    wr(BPX_OFF_SENSE, {6'h00, BPX_SENS_RISE});
    ext_val[0] <= 1'b0;
    tick(6);
    wr(BPX_OFF_OPT, 8'h00);
    tick(4);
    `CHK("forced edge", 1'b1, irq_req[0])
    // Safe enable and safe disable with the pin held low raise nothing
    vec_fetch <= 4'h1;
    tick(1);
    vec_fetch <= 4'h0;
    wr(BPX_OFF_OPT, 8'h01);
    tick(4);
    `CHK("safe enable", 1'b0, irq_req[0])
    wr(BPX_OFF_SENSE, {6'h00, BPX_SENS_FALL});
    wr(BPX_OFF_OPT, 8'h00);
    tick(4);
    `CHK("safe disable", 1'b0, irq_req[0])
    wr(BPX_OFF_SENSE, {6'h00, BPX_SENS_RISE});
    finish_test();
  end
  // Hang guard: the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
endmodule : bpx_port_tb
`default_nettype wire
